// ===== rtl/cbrr_result_regs.sv
/*
  Read-only result registers for cells 13, 14 and the stack voltage.
  Assumes a scan engine on sys_clk delivering codes already scaled
  (cells 5 V full scale, stack 65 V full scale) and a one-cycle
  read-latency register port on the same clock.
*/
// Contract
// RULE1: cell code sits in bits 15 to 2
// RULE2: cell code span equals five volts
// RULE3: disabled skipped cell keeps its result
// RULE4: cell registers read-only, reset to zero
// RULE5: stack code sits in bits 15 to 2
// RULE6: stack code span equals 65 volts
// RULE7: disabled skipped stack keeps its result
// RULE8: stack register read-only, reset to zero
// RULE9: low bits zero, writes ignored
`timescale 1ns/10ps
`default_nettype none
`include "cbrr_defs.svh"
module cbrr_result_regs
  import cbrr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output cbrr_word_t      regRdata,
  input  wire cbrr_conv_t thirteenthCellConv,
  input  wire cbrr_conv_t fourteenthCellConv,
  input  wire cbrr_conv_t stackConv,
  input  wire logic [1:0] cellChannelMeasureEnable,
  input  wire logic       stackMeasureEnable,
  input  wire logic       filteredReadbackSelect
);
  // full-scale figures are fixed by the converter front end; codes arrive scaled
  localparam int CellFsMv  = `CBRR_CELL_FS_MV;  // RULE2
  localparam int StackFsMv = `CBRR_STACK_FS_MV; // RULE6

  typedef struct packed {
    cbrr_word_t rdata;
  } cbrr_top_t;

  cbrr_top_t  st_r;
  cbrr_top_t  st_nxt;
  cbrr_word_t words [3];
  cbrr_conv_t convs [3];
  logic [2:0] enables;

  assign convs[0] = thirteenthCellConv;
  assign convs[1] = fourteenthCellConv;
  assign convs[2] = stackConv;
  assign enables  = {stackMeasureEnable, cellChannelMeasureEnable};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gSlot
      cbrr_result_slot uSlot (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .conv       (convs[g]),
        .measEnable (enables[g]),
        .filtSel    (filteredReadbackSelect),
        .word       (words[g])
      );
    end
  endgenerate

  function automatic cbrr_word_t decode(input logic [7:0] a,
                                        input cbrr_word_t w0,
                                        input cbrr_word_t w1,
                                        input cbrr_word_t w2);
    case (a)
      `CBRR_OFF_THIRTEENTH_CELL_RESULT_FIELD: decode = w0;
      `CBRR_OFF_FOURTEENTH_CELL_RESULT_FIELD: decode = w1;
      `CBRR_OFF_STACK:  decode = w2;
      default:          decode = 16'h0000;
    endcase
  endfunction : decode

  // regWr and regWdata are accepted and dropped: every register here is read-only
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 16'h0000;
    if (regRd) begin
      st_nxt.rdata = decode(regAddr, words[0], words[1], words[2]); // RULE4 RULE8 RULE9
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;

  sequence s_readStack;
    regRd && regAddr == `CBRR_OFF_STACK;
  endsequence

  a_stack_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_readStack |=> regRdata == $past(words[2])) // RULE8
    else $error("stack read returned wrong data");
  a_cell_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    regRd && regAddr == `CBRR_OFF_THIRTEENTH_CELL_RESULT_FIELD |=> regRdata == $past(words[0])) // RULE4
    else $error("cell 13 read returned wrong data");
  // select must hold across the window, else the mux alone moves the word
  a_write_ignored: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE9
    regWr && !(thirteenthCellConv.valid)
      ##1 $stable(filteredReadbackSelect) |-> $stable(words[0]))
    else $error("write altered a read-only result");
  // a skipped conversion on a disabled channel is not stored, so leave it out
  a_cell_align: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE1
    thirteenthCellConv.valid && !filteredReadbackSelect && !regWr
      && !(thirteenthCellConv.skipped && !cellChannelMeasureEnable[0])
      ##1 !filteredReadbackSelect |-> words[0][15:2] == $past(thirteenthCellConv.raw))
    else $error("cell code not left aligned");
  a_stack_align: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
    stackConv.valid && filteredReadbackSelect
      && !(stackConv.skipped && !stackMeasureEnable)
      ##1 filteredReadbackSelect |-> words[2][15:2] == $past(stackConv.filt))
    else $error("stack code not left aligned");
  a_stack_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE7
    stackConv.valid && stackConv.skipped && !stackMeasureEnable
      ##1 $stable(filteredReadbackSelect) |-> $stable(words[2]))
    else $error("skipped disabled stack changed");
  a_idle_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    !regRd |=> regRdata == 16'h0000) // RULE9
    else $error("read data not zero outside read");
  a_reset_zero: assert property (@(posedge sys_clk)
    !resetn |=> words[1] == `CBRR_RESET_VAL) // RULE4
    else $error("result not cleared by reset");
  a_scale_fixed: assert property (@(posedge sys_clk)
    CellFsMv == 5000 && StackFsMv == 65000) // RULE2 RULE6
    else $error("full-scale figures wrong");
endmodule : cbrr_result_regs
`default_nettype wire

// ===== rtl/cbrr_defs.svh
/*
  Offsets, field positions, reset values and scale figures of the cell and
  stack result registers. Assumes inclusion by bare name from rtl/.
*/
`ifndef CBRR_DEFS_SVH
`define CBRR_DEFS_SVH
`define CBRR_OFF_THIRTEENTH_CELL_RESULT_FIELD    8'h53
`define CBRR_OFF_FOURTEENTH_CELL_RESULT_FIELD    8'h54
`define CBRR_OFF_STACK     8'h55
`define CBRR_RES_MSB       15
`define CBRR_RES_LSB       2
`define CBRR_RESET_VAL     16'h0000
`define CBRR_CELL_FS_MV    5000
`define CBRR_STACK_FS_MV   65000
`endif

// ===== rtl/cbrr_pkg.sv
/*
  Types of the cell and stack result registers.
  Assumes cbrr_defs.svh supplies the numeric constants.
*/
package cbrr_pkg;
  typedef logic [13:0] cbrr_code_t;
  typedef logic [15:0] cbrr_word_t;
  // one conversion delivered by the scan engine
  typedef struct packed {
    logic       valid;
    logic       skipped;
    cbrr_code_t raw;
    cbrr_code_t filt;
  } cbrr_conv_t;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
  } cbrr_bus_t;
endpackage : cbrr_pkg

// ===== rtl/cbrr_result_slot.sv
/*
  One result holding register: keeps raw and filtered codes of one channel
  and presents the selected one left-aligned. Assumes scan-engine inputs
  on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cbrr_defs.svh"
module cbrr_result_slot
  import cbrr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire cbrr_conv_t conv,
  input  wire logic       measEnable,
  input  wire logic       filtSel,
  output cbrr_word_t      word
);
  typedef struct packed {
    cbrr_code_t raw;
    cbrr_code_t filt;
  } cbrr_slot_t;

  cbrr_slot_t st_r;
  cbrr_slot_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // a disabled channel that the scan skipped keeps its data
    if (conv.valid && !(conv.skipped && !measEnable)) begin // RULE3 RULE7
      st_nxt.raw  = conv.raw;
      st_nxt.filt = conv.filt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= '0; // RULE4 RULE8
    end else begin
      st_r <= st_nxt;
    end
  end

  // result msb at bit 15, low two bits read zero
  assign word = {(filtSel ? st_r.filt : st_r.raw), 2'b00}; // RULE1 RULE5 RULE9

  a_skip_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    conv.valid && conv.skipped && !measEnable |=> $stable(st_r)) // RULE3
    else $error("skipped disabled channel changed its result");
  a_low_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    word[1:0] == 2'b00) // RULE9
    else $error("unused low bits not zero");
endmodule : cbrr_result_slot
`default_nettype wire

// ===== testbench/cbrr_result_regs_bench.sv
/*
  Self-checking bench for the cell and stack result registers.
  Assumes the rtl package and defines header are compiled ahead of it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cbrr_defs.svh"
`define CHK(nm, e, a) begin totalChecks++; if ((a) !== (e)) begin numErrors++; \
  $display("mismatch %s expected %h seen %h", nm, e, a); end end
module cbrr_result_regs_bench
  import cbrr_pkg::*;
;
  logic        sys_clk     = 1'b0;
  logic        resetn      = 1'b0;
  logic [7:0]  regAddr     = 8'h00;
  logic [15:0] regWdata    = 16'h0000;
  logic        regWr       = 1'b0;
  logic        regRd       = 1'b0;
  logic [2:0]  en          = 3'h0;
  logic        filtSel     = 1'b0;
  cbrr_word_t  regRdata;
  cbrr_conv_t  cv [3];
  cbrr_code_t  expR [3];
  cbrr_code_t  expF [3];
  int          numErrors   = 0;
  int          totalChecks = 0;

  always #5 sys_clk = ~sys_clk;

  cbrr_result_regs cbrr_result_regs_inst (
    .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .thirteenthCellConv(cv[0]),
    .fourteenthCellConv(cv[1]), .stackConv(cv[2]), .cellChannelMeasureEnable(en[1:0]),
    .stackMeasureEnable(en[2]), .filteredReadbackSelect(filtSel));

  task automatic rd(input logic [7:0] a, input cbrr_word_t e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    `CHK("regRdata", e, regRdata)
  endtask : rd

  task automatic wr(input logic [7:0] a);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= 16'hffff;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr

  // skipped conversions on enabled channels still land
  task automatic conv(input int i, input logic sk, input cbrr_code_t r, input cbrr_code_t f);
    @(posedge sys_clk);
    // cells land under raw readback, stack under filtered, so both align checks fire
    filtSel <= (i == 2);
    cv[i] <= {1'b1, sk, r, f};
    if (!(sk && !en[i])) begin
      expR[i] = r;
      expF[i] = f;
    end
    @(posedge sys_clk);
    cv[i].valid <= 1'b0;
  endtask : conv

  task automatic chk_all(input string nm);
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      filtSel <= s[0];
      for (int i = 0; i < 3; i++)
        rd(`CBRR_OFF_THIRTEENTH_CELL_RESULT_FIELD + 8'(i), {(s != 0) ? expF[i] : expR[i], 2'b00});
    end
    $display("test %s done", nm);
  endtask : chk_all

  task automatic endOfTest;
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : endOfTest

  initial begin
    #20000;
    numErrors++;
    endOfTest();
  end

  initial begin
    for (int i = 0; i < 3; i++) begin
      cv[i] = '0;
      expR[i] = '0;
      expF[i] = '0;
    end
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    chk_all("reset");
    rd(8'h56, 16'h0000);
    en <= 3'h7;
    for (int i = 0; i < 3; i++)
      conv(i, i[0], cbrr_code_t'(14'h3fff - 14'h1555 * i), cbrr_code_t'(14'h0001 << (5 * i)));
    chk_all("alignment");
    for (int i = 0; i < 3; i++)
      wr(`CBRR_OFF_THIRTEENTH_CELL_RESULT_FIELD + 8'(i));
    chk_all("write ignored");
    en <= 3'h0;
    for (int i = 0; i < 3; i++)
      conv(i, 1'b1, 14'h0123, 14'h0321);
    chk_all("skip hold");
    for (int i = 0; i < 3; i++)
      conv(i, 1'b0, 14'h0abc, 14'h1cba);
    chk_all("disabled update");
    endOfTest();
  end
endmodule : cbrr_result_regs_bench
`default_nettype wire
